// [hdl/pdl_host.sv]
// Notes on behaviour
// [R01] converter keeps one twelve-bit register per strobe
// [R02] converter captures data as chip select rises
// [R03] open converter inputs read as zero
// [R04] bits are positive-true binary weights
// [R05] unipolar: straight binary codes
// [R06] bipolar: offset binary, 800 is zero
// [R07] twos complement input: invert bit eleven
// [R08] chip select is decode OR write enable
// [R09] three port lines select among eight ports
// [R10] strobes gated with decode give acknowledge
// [R11] io space select enables the port decoder
// [R12] wait flip-flop holds acknowledge, stretches strobe
// [R13] flip-flop set on clock edge ends cycle
// [R14] converter holds last code between strobes
`timescale 1ns/1ps
`default_nettype none
module pdl_host
	import pdl_pkg::*;
#(
	parameter int               CODE_W   = pdl_pkg::CODE_W,
	parameter logic [2:0]       OWN_PORT = 3'h3
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	// user request side
	input  wire logic              req_valid,
	input  wire pdl_pkg::pdl_req_t req,
	output logic                   req_ready,
	output logic                   done,
	// converter pins
	output pdl_pkg::pdl_pins_t     pins,
	output logic [2:0]             port_select_lines,
	output logic                   io_space_select_n,
	output logic                   write_enable_n,
	output logic                   upper_byte_strobe_n,
	output logic                   lower_byte_strobe_n,
	output logic                   transfer_acknowledge_n,
	output logic                   data_memory_acknowledge
);
	import pdl_pkg::*;

	initial begin
		if (CODE_W != pdl_pkg::CODE_W) $error("code width fixed at twelve");
	end

	pdl_state_t        state;
	pdl_state_t        next_state;
	logic [3:0]        cnt;
	logic [CODE_W-1:0] code;
	logic              decoded_n;
	logic              cs_n;
	logic              wait_q;

	// convert a requested value into the bit pattern on the pins
	function automatic logic [CODE_W-1:0] to_pins(input pdl_req_t r);
		logic [CODE_W-1:0] v;
		v = r.code;
		// positive-true weights, twos complement needs top bit flipped
		if (r.twos) v[TOP_BIT] = ~v[TOP_BIT]; // R07 R04 R06
		return v;
	endfunction

	// next state: setup, strobe low for the minimum, one wait, release
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:  if (req_valid) next_state = ST_SETUP;
			ST_SETUP: if (cnt == 4'(SETUP_CYC - 1)) next_state = ST_LOW;
			ST_LOW:   if (cnt == 4'(CS_LOW_CYC - 1)) next_state = ST_WAIT;
			ST_WAIT:  if (wait_q) next_state = ST_HOLD; // R12
			ST_HOLD:  next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!reset_n) state <= ST_IDLE;
		else state <= next_state;
	end

	// phase counter, cleared on every state change
	always_ff @(posedge core_clk) begin
		if (!reset_n || next_state != state) cnt <= 4'h0;
		else cnt <= cnt + 4'h1;
	end

	// data held from setup through hold so the rising edge sees it stable
	always_ff @(posedge core_clk) begin
		if (!reset_n) code <= CODE_RESET; // R03
		else if (state == ST_IDLE && req_valid) code <= to_pins(req); // R05
	end

	// wait flip-flop: set on the clock edge after the strobe is stretched
	always_ff @(posedge core_clk) begin
		if (!reset_n) wait_q <= 1'b0;
		else wait_q <= (state == ST_WAIT) && !wait_q; // R13
	end

	// write enable low for the low phase plus the first wait cycle only;
	// holding it through the acknowledge cycle would add a second wait
	always_ff @(posedge core_clk) begin
		if (!reset_n) write_enable_n <= 1'b1;
		else write_enable_n <= !(next_state == ST_LOW ||
			(next_state == ST_WAIT && state != ST_WAIT)); // R12
	end

	// address and space stay asserted for the whole access
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			port_select_lines <= PORT_RESET;
			io_space_select_n <= 1'b1;
		end else begin
			port_select_lines <= OWN_PORT; // R09
			io_space_select_n <= !(next_state != ST_IDLE); // R11
		end
	end

	pdl_strobe_gate #(
		.PORT_W (3)
	) u_gate (
		.port_select_lines (port_select_lines),
		.own_port          (OWN_PORT),
		.io_space_select_n (io_space_select_n),
		.write_enable_n    (write_enable_n),
		.decoded_n         (decoded_n),
		.chip_select_n     (cs_n)
	);

	// byte strobes follow write enable; acknowledge is their gated form
	assign upper_byte_strobe_n     = write_enable_n;
	assign lower_byte_strobe_n     = write_enable_n;
	assign transfer_acknowledge_n  = decoded_n |
		(upper_byte_strobe_n & lower_byte_strobe_n); // R10
	// held low while decoded until the wait flip-flop sets
	assign data_memory_acknowledge = decoded_n | wait_q; // R12 R13

	// one driver for the whole pin bundle: code bits above the strobe
	assign pins                    = {code, cs_n}; // R01 R02 R14
	assign req_ready               = (state == ST_IDLE);
	assign done                    = (state == ST_HOLD);

	// the strobe low phase lasts the minimum width plus one wait cycle
	sequence s_cs_fall;
		$fell(pins.chip_select_n);
	endsequence
	sequence s_cs_low_len;
		!pins.chip_select_n [*8] ##1 !pins.chip_select_n;
	endsequence

	chk_cs_width: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
		s_cs_fall |-> s_cs_low_len ##1 pins.chip_select_n)
		else $error("chip select low width wrong");
	chk_cs_gate: assert property (@(posedge core_clk) disable iff (!reset_n) // R08
		!pins.chip_select_n |-> !decoded_n && !write_enable_n)
		else $error("chip select low without decode and write");
	chk_data_stable: assert property (@(posedge core_clk) disable iff (!reset_n) // R02
		!pins.chip_select_n |=> $stable(pins.parallel_code_bits))
		else $error("data moved while strobe low");
	chk_idle_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
		req_ready && !req_valid |=> $stable(pins.parallel_code_bits))
		else $error("code changed without request");
	chk_twos_flip: assert property (@(posedge core_clk) disable iff (!reset_n) // R07
		req_ready && req_valid |=> pins.parallel_code_bits ==
			{$past(req.code[11]) ^ $past(req.twos), $past(req.code[10:0])})
		else $error("top bit inversion wrong");
	chk_ack_wait: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
		$rose(wait_q) |-> data_memory_acknowledge ##1 done)
		else $error("acknowledge not released by wait flop");
	chk_ack_low: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
		!write_enable_n |-> !transfer_acknowledge_n)
		else $error("transfer acknowledge missing");
	chk_decode: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
		io_space_select_n |-> decoded_n)
		else $error("decode active outside io space");
	chk_one_wait: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
		$fell(pins.chip_select_n) |-> !data_memory_acknowledge [*8]
			##1 !data_memory_acknowledge ##1 data_memory_acknowledge)
		else $error("wait state length wrong");
endmodule
`default_nettype wire

// [hdl/pdl_pkg.sv]
package pdl_pkg;
	localparam int CODE_W       = 12;
	localparam int PORT_W       = 3;
	localparam int TOP_BIT      = 11;
	// strobe timing: least low width of the chip select
	localparam int CS_MIN_NS    = 40;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CS_LOW_CYC   = (CS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC    = 1;
	localparam int WAIT_CYC     = 1;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
	localparam logic [CODE_W-1:0] CODE_MID   = 12'h800;
	localparam logic [PORT_W-1:0] PORT_RESET = 3'h0;

	// one write request from the user side
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic              twos;
	} pdl_req_t;

	// pins driven toward the converter
	typedef struct packed {
		logic [CODE_W-1:0] parallel_code_bits;
		logic              chip_select_n;
	} pdl_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOW   = 3'b010,
		ST_WAIT  = 3'b011,
		ST_HOLD  = 3'b100
	} pdl_state_t;
endpackage

// [hdl/pdl_strobe_gate.sv]
`timescale 1ns/1ps
`default_nettype none
// decode and chip-select glue, purely combinational
module pdl_strobe_gate #(
	parameter int PORT_W = 3
) (
	// decode inputs
	input  wire logic [PORT_W-1:0] port_select_lines,
	input  wire logic [PORT_W-1:0] own_port,
	input  wire logic              io_space_select_n,
	input  wire logic              write_enable_n,
	// glue outputs
	output logic                   decoded_n,
	output logic                   chip_select_n
);
	initial begin
		if (PORT_W < 1) $error("port width must be at least 1");
	end

	// io space enables the decoder, low-true hit
	assign decoded_n     = io_space_select_n |
		(port_select_lines != own_port); // R09 R11
	// low only when address hit and write both low
	assign chip_select_n = decoded_n | write_enable_n; // R08
endmodule
`default_nettype wire

// [verification/pdl_dac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pdl_dac_model
	import pdl_pkg::*;
(
	// converter pins
	input  wire pdl_pkg::pdl_pins_t pins,
	// converted value
	output logic [11:0]             held_code,
	output int                      bipolar_steps
);
	import pdl_pkg::*;
	// open inputs settle low, so the register starts at zero
	initial held_code = 12'h000;
	// single register, loaded only as chip select returns high
	always @(posedge pins.chip_select_n)
		held_code <= pins.parallel_code_bits;
	// positive-true weights; offset binary puts zero at 800
	always_comb bipolar_steps = int'(held_code) - 2048;
endmodule
`default_nettype wire

// [verification/pdl_host_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pdl_host_tb;
	import pdl_pkg::*;
	logic              core_clk;
	logic              reset_n;
	logic              req_valid;
	pdl_req_t          req;
	logic              req_ready;
	logic              done;
	pdl_pins_t         pins;
	logic [2:0]        port_sel;
	logic [11:0]       held_code;
	int                bip;
	int                failures;
	int                check_count;
	pdl_host DUT (.core_clk(core_clk), .reset_n(reset_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.done(done), .pins(pins), .port_select_lines(port_sel),
		.io_space_select_n(), .write_enable_n(),
		.upper_byte_strobe_n(), .lower_byte_strobe_n(),
		.transfer_acknowledge_n(), .data_memory_acknowledge());
	pdl_dac_model dac (.pins(pins), .held_code(held_code),
		.bipolar_steps(bip));
	// free-running 200 MHz clock
	always #2.5 core_clk = ~core_clk;
	// twos complement callers get the top bit flipped
	function automatic logic [11:0] exp_code(logic [11:0] c, logic t);
		return c ^ {t, 11'h000};
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		check_count++;
		if (e !== s) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one write; counts cycles to done and the strobe's low width
	task automatic write_word(logic [11:0] c, logic t);
		int n;
		int lo;
		@(negedge core_clk);
		req_valid = 1'b1;
		req.code = c;
		req.twos = t;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		@(negedge core_clk);
		req_valid = 1'b0;
		req.code = ~c; // bus noise must not reach the converter
		n = 1;
		lo = 0;
		while (done !== 1'b1 && n < 50) begin
			if (pins.chip_select_n === 1'b0)
				lo++;
			@(negedge core_clk);
			n++;
		end
		chk("done latency", 12, n);
		chk("strobe width", 9, lo);
		chk("port", 3'h3, port_sel);
		chk("code", exp_code(c, t), held_code);
		chk("bipolar", int'(exp_code(c, t)) - 2048, bip);
		@(negedge core_clk);
		chk("done pulse", 1'b0, done);
		chk("hold", exp_code(c, t), held_code);
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	logic [12:0] corner [5] = '{13'h0000, 13'h1ffe, 13'h1000,
		13'h0001, 13'h0fff};
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		failures = 0;
		check_count = 0;
		void'($urandom(31390));
		repeat (6) @(negedge core_clk);
		reset_n = 1'b1;
		chk("reset cs", 1'b1, pins.chip_select_n);
		chk("reset code", 12'h000, held_code);
		chk("reset ready", 1'b1, req_ready);
		// all-zero, all-one, mid-scale and twos complement corners
		foreach (corner[i])
			write_word(corner[i][12:1], corner[i][0]);
		repeat (20)
			write_word(12'($urandom), 1'($urandom));
		wrap_up();
	end
endmodule
`default_nettype wire
